// ==== hdl/uwb_bar_match.sv ====
`timescale 1ns/10ps
// Purpose: masked base compare and direct translation
// Assumes: mask has ones on the compared bits
// Notes: purely combinational
module uwb_bar_match (
    input wire logic [31:0] addr,
    input wire logic [31:0] base,
    input wire logic [31:0] mask,
    input wire logic [31:0] xbase,
    output logic hit,
    output logic [31:0] xaddr
);
    assign hit = (((addr ^ base) & mask) == 32'h0000_0000);
    assign xaddr = (xbase & mask) | (addr & ~mask);
endmodule // uwb_bar_match

// ==== hdl/uwb_lut_if.sv ====
`timescale 1ns/10ps
// Purpose: carries the lookup table ports between controller and memory
// Assumes: one write port, two registered read ports
// Notes: widths are parameters
interface uwb_lut_if #(parameter int AW = 6, parameter int DW = 32);
    logic wr_en;
    logic [AW-1:0] wr_idx;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] ra_idx;
    logic [DW-1:0] ra_data;
    logic [AW-1:0] rb_idx;
    logic [DW-1:0] rb_data;
    modport mem (input wr_en, input wr_idx, input wr_data, input ra_idx,
                 output ra_data, input rb_idx, output rb_data);
    modport ctl (output wr_en, output wr_idx, output wr_data, output ra_idx,
                 input ra_data, output rb_idx, input rb_data);
endinterface // uwb_lut_if

// ==== hdl/uwb_lut_mem.sv ====
`timescale 1ns/10ps
// Purpose: window 2 page translation table storage
// Assumes: read data one cycle after the index
// Notes: no reset on the array, enables are kept outside
module uwb_lut_mem #(
    parameter int DEPTH = 64,
    parameter int DW = 32
) (
    input wire logic pclk,
    uwb_lut_if.mem lut
);
    logic [DW-1:0] mem_q [DEPTH];

    always_ff @(posedge pclk) begin
        if (lut.wr_en) begin
            mem_q[lut.wr_idx] <= lut.wr_data;
        end
    end

    always_ff @(posedge pclk) begin
        lut.ra_data <= mem_q[lut.ra_idx];
        lut.rb_data <= mem_q[lut.rb_idx];
    end
endmodule // uwb_lut_mem

// ==== hdl/uwb_pkg.sv ====
// Purpose: constants and types for the upstream window base address block
// Assumes: registers addressed by index, byte address is four times the index
// Notes: setup, translated-base, page control and lookup entries live here too
// Behaviour
// - window 1 size and type come from its setup register at ECh.
// - each window 1 base bit 31:6 is writable only where the setup bit is one.
// - setup bit 31 at zero disables window 1 so it claims nothing.
// - window 1 spans 4KB to 2GB as memory and 64B to 256B as IO.
// - window 1 hits are translated through the translated base at E8h.
// - window 1 bit 0 is space, bits 2:1 address type, bits 5:4 read zero.
// - bit 3 of both windows reports prefetchable memory, reset zero.
// - window 2 type is always 32-bit code 00 and bits 13:4 read zero.
// - window 2 base bits 31:14 set the range claimed for upstream memory.
// - window 2 translation goes through a lookup table.
// - window 2 spans 16KB up to 2GB.
// - window 2 has 64 equal pages sized by the control register at 6Ah.
// - a window 2 page is off when bit 0 of its table entry (100h-13Fh) is zero.
// - the count of writable window 2 base bits follows the page size.
package uwb_pkg;
    localparam logic [9:0] UWB_IDX_W1_BASE = 10'h058;
    localparam logic [9:0] UWB_IDX_W2_BASE = 10'h05C;
    localparam logic [9:0] UWB_IDX_PGCTL = 10'h06A;
    localparam logic [9:0] UWB_IDX_W1_XBASE = 10'h0E8;
    localparam logic [9:0] UWB_IDX_W1_SETUP = 10'h0EC;
    localparam logic [9:0] UWB_IDX_LAST_FWD = 10'h0F0;
    localparam logic [9:0] UWB_IDX_LUT_FIRST = 10'h100;
    localparam logic [9:0] UWB_IDX_LUT_LAST = 10'h1FF;
    localparam int UWB_W1_LO = 6;
    localparam int UWB_W1_IO_TOP = 8;
    localparam int UWB_W1_MEM_LO = 12;
    localparam int UWB_W2_LO = 14;
    localparam int UWB_PAGE_LO = 8;
    localparam logic [4:0] UWB_PGCODE_MAX = 5'h11;
    localparam int UWB_SETUP_EN = 31;
    localparam int UWB_F_SPACE = 0;
    localparam int UWB_F_PREF = 3;
    localparam int UWB_PGCTL_PREF = 8;
    localparam int UWB_LUT_EN = 0;
    localparam logic [31:0] UWB_RST_REG = 32'h0000_0000;
    typedef enum logic [1:0] {
        UWB_ST_IDLE = 2'b00,
        UWB_ST_LOAD = 2'b01,
        UWB_ST_RESP = 2'b11
    } uwb_state_t;
endpackage

// ==== hdl/uwb_top.sv ====
// Local design decision: the APB register port.
`timescale 1ns/10ps
// Purpose: upstream window 1 and window 2 base registers with address claim
// Assumes: APB slave on pclk, secondary requests come from logic on pclk
// Notes: one wait state on every access, claim answers two cycles after request
module uwb_top
    import uwb_pkg::*;
#(
    parameter int PAGES = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sec_valid,
    input wire logic [31:0] sec_addr,
    input wire logic sec_io,
    output logic fwd_valid,
    output logic [31:0] fwd_addr,
    output logic fwd_win2
);
    localparam int PW = $clog2(PAGES);

    uwb_state_t st_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    logic [31:0] w1_setup_q;
    logic [31:0] w1_xbase_q;
    logic [31:0] pgctl_q;
    logic [31:6] w1_base_q;
    logic [31:14] w2_base_q;
    logic [PAGES-1:0] pg_en_q;
    logic [31:0] last_fwd_q;

    logic [9:0] idx;
    logic is_lut;
    logic [PW-1:0] lut_idx;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] w1_mask;
    logic [31:6] w1_wr;
    logic [31:0] w2_mask;
    logic [31:0] pg_mask;
    logic [4:0] pg_code;
    logic [5:0] w2_shift;
    logic [5:0] pg_shift;
    logic [31:0] w1_rd;
    logic [31:0] w2_rd;
    logic [31:0] rd_mux;
    logic rd_ok;
    logic [31:0] w1_xaddr;
    logic w1_match;
    logic w2_match;
    logic [31:0] sec_shift;

    logic s1_valid_q;
    logic [31:0] s1_addr_q;
    logic s1_w1_q;
    logic [31:0] s1_w1x_q;
    logic s1_w2_q;
    logic [PW-1:0] s1_page_q;
    logic fwd_valid_q;
    logic [31:0] fwd_addr_q;
    logic fwd_win2_q;

    uwb_lut_if #(.AW(PW), .DW(32)) lut ();

    uwb_lut_mem #(.DEPTH(PAGES), .DW(32)) u_mem (
        .pclk(pclk),
        .lut(lut.mem)
    );

    // address decode, index view of the byte address
    assign idx = paddr[11:2];
    assign is_lut = (idx >= UWB_IDX_LUT_FIRST) && (idx < UWB_IDX_LUT_FIRST + 10'(PAGES));
    assign lut_idx = PW'(idx - UWB_IDX_LUT_FIRST);
    assign wr_fire = (st_q == UWB_ST_RESP) && psel && penable && pwrite;
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // window 1 compare mask from the setup register
    always_comb begin
        w1_mask = {w1_setup_q[31:UWB_W1_LO], 6'h00};
        if (w1_setup_q[UWB_F_SPACE]) begin
            w1_mask[31:UWB_W1_IO_TOP] = '1;
        end else begin
            w1_mask[UWB_W1_MEM_LO-1:UWB_W1_LO] = '0;
            w1_mask[31] = 1'b1;
        end
    end

    // setup bit gates writability; fixed compare bits must not become writable
    assign w1_wr = wmask[31:6] & w1_mask[31:6] & w1_setup_q[31:6];

    // page code clamps so the window never exceeds 2GB
    assign pg_code = (pgctl_q[4:0] > UWB_PGCODE_MAX) ? UWB_PGCODE_MAX : pgctl_q[4:0];
    assign w2_shift = 6'(UWB_W2_LO) + {1'b0, pg_code};
    assign pg_shift = 6'(UWB_PAGE_LO) + {1'b0, pg_code};
    assign w2_mask = 32'hFFFF_FFFF << w2_shift;
    assign pg_mask = 32'hFFFF_FFFF << pg_shift;

    // readback images; base bits outside the mask read as zero
    assign w1_rd = ({w1_base_q, 6'h00} & w1_mask) |
                   {28'h0000000, w1_setup_q[3:0]};
    assign w2_rd = ({w2_base_q, 14'h0000} & w2_mask) |
                   {28'h0000000, pgctl_q[UWB_PGCTL_PREF], 3'b000};

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        if (is_lut) begin
            rd_mux = {lut.ra_data[31:1], pg_en_q[lut_idx]};
        end else if (idx >= UWB_IDX_LUT_FIRST && idx <= UWB_IDX_LUT_LAST) begin
            rd_mux = 32'h0000_0000;
        end else begin
            unique case (idx)
                UWB_IDX_W1_BASE: rd_mux = w1_rd;
                UWB_IDX_W2_BASE: rd_mux = w2_rd;
                UWB_IDX_PGCTL: rd_mux = pgctl_q;
                UWB_IDX_W1_XBASE: rd_mux = w1_xbase_q;
                UWB_IDX_W1_SETUP: rd_mux = w1_setup_q;
                UWB_IDX_LAST_FWD: rd_mux = last_fwd_q;
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // bus handshake: setup, one load cycle, then ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= UWB_ST_IDLE;
        end else begin
            unique case (st_q)
                UWB_ST_IDLE: begin
                    if (psel && !penable) begin
                        st_q <= UWB_ST_LOAD;
                    end
                end
                UWB_ST_LOAD: st_q <= UWB_ST_RESP;
                UWB_ST_RESP: st_q <= UWB_ST_IDLE;
                default: st_q <= UWB_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= UWB_RST_REG;
        end else if (st_q == UWB_ST_LOAD) begin
            pready_q <= 1'b1;
            pslverr_q <= ~rd_ok;
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // loaded by software through the APB port before traffic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w1_setup_q <= UWB_RST_REG;
            w1_xbase_q <= UWB_RST_REG;
            pgctl_q <= UWB_RST_REG;
        end else if (wr_fire && rd_ok) begin
            if (idx == UWB_IDX_W1_SETUP) begin
                w1_setup_q <= (pwdata & wmask) | (w1_setup_q & ~wmask);
            end
            if (idx == UWB_IDX_W1_XBASE) begin
                w1_xbase_q <= (pwdata & wmask) | (w1_xbase_q & ~wmask);
            end
            if (idx == UWB_IDX_PGCTL) begin
                pgctl_q <= (pwdata & wmask) | (pgctl_q & ~wmask);
            end
        end
    end

    // base bits change only where writable; low fields are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w1_base_q <= '0;
            w2_base_q <= '0;
        end else if (wr_fire) begin
            if (idx == UWB_IDX_W1_BASE) begin
                w1_base_q <= (pwdata[31:6] & w1_wr) | (w1_base_q & ~w1_wr);
            end
            if (idx == UWB_IDX_W2_BASE) begin
                w2_base_q <= (pwdata[31:14] & wmask[31:14] & w2_mask[31:14]) |
                             (w2_base_q & ~(wmask[31:14] & w2_mask[31:14]));
            end
        end
    end

    // page enables kept in flops so every page is off after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_en_q <= '0;
        end else if (wr_fire && is_lut && pstrb[0]) begin
            pg_en_q[lut_idx] <= pwdata[UWB_LUT_EN];
        end
    end

    assign lut.wr_en = wr_fire && is_lut && (pstrb == 4'hF);
    assign lut.wr_idx = lut_idx;
    assign lut.wr_data = pwdata;
    assign lut.ra_idx = lut_idx;

    // claim stage 1: range compare, table lookup launched
    uwb_bar_match u_w1 (
        .addr(sec_addr),
        .base({w1_base_q, 6'h00}),
        .mask(w1_mask),
        .xbase(w1_xbase_q),
        .hit(w1_match),
        .xaddr(w1_xaddr)
    );

    uwb_bar_match u_w2 (
        .addr(sec_addr),
        .base({w2_base_q, 14'h0000}),
        .mask(w2_mask),
        .xbase(32'h0000_0000),
        .hit(w2_match),
        .xaddr()
    );

    assign sec_shift = sec_addr >> pg_shift;
    assign lut.rb_idx = sec_shift[PW-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_valid_q <= 1'b0;
            s1_addr_q <= UWB_RST_REG;
            s1_w1_q <= 1'b0;
            s1_w1x_q <= UWB_RST_REG;
            s1_w2_q <= 1'b0;
            s1_page_q <= '0;
        end else begin
            s1_valid_q <= sec_valid;
            s1_addr_q <= sec_addr;
            // io type must match, setup enable gates the window
            s1_w1_q <= sec_valid && w1_match && w1_setup_q[UWB_SETUP_EN] &&
                       (sec_io == w1_setup_q[UWB_F_SPACE]);
            s1_w1x_q <= w1_xaddr;
            s1_w2_q <= sec_valid && w2_match && !sec_io;
            s1_page_q <= sec_shift[PW-1:0];
        end
    end

    // claim stage 2: page enable and table translation; window 1 wins overlaps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_valid_q <= 1'b0;
            fwd_addr_q <= UWB_RST_REG;
            fwd_win2_q <= 1'b0;
        end else if (s1_w1_q) begin
            fwd_valid_q <= 1'b1;
            fwd_addr_q <= s1_w1x_q;
            fwd_win2_q <= 1'b0;
        end else if (s1_w2_q && pg_en_q[s1_page_q]) begin
            fwd_valid_q <= 1'b1;
            fwd_addr_q <= (lut.rb_data & pg_mask) | (s1_addr_q & ~pg_mask);
            fwd_win2_q <= 1'b1;
        end else begin
            fwd_valid_q <= 1'b0;
            fwd_win2_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_fwd_q <= UWB_RST_REG;
        end else if (fwd_valid_q) begin
            last_fwd_q <= fwd_addr_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign fwd_valid = fwd_valid_q;
    assign fwd_addr = fwd_addr_q;
    assign fwd_win2 = fwd_win2_q;
endmodule // uwb_top

// ==== testbench/uwb_sec_partner.sv ====
// Purpose: secondary bus master issuing one address per call
// Assumes: requests on pclk, no backpressure from the block
// Notes: idle address is the inverse of the last, never stale
`timescale 1ns/10ps
module uwb_sec_partner (
    input wire logic pclk,
    output logic sec_valid,
    output logic [31:0] sec_addr,
    output logic sec_io
);
    initial begin
        sec_valid = 1'b0;
        sec_addr = 32'h0000_0000;
        sec_io = 1'b0;
    end
    task automatic issue(input logic [31:0] a, input logic io, input int gap);
        repeat (gap) @(posedge pclk);
        sec_valid <= 1'b1;
        sec_addr <= a;
        sec_io <= io;
        @(posedge pclk);
        sec_valid <= 1'b0;
        sec_addr <= ~a;
        sec_io <= ~io;
    endtask
endmodule // uwb_sec_partner

// ==== testbench/uwb_tb_top.sv ====
// Purpose: self-checking bench for uwb_top
// Assumes: apb with one wait state, claim two edges after request
// Notes: lookup entries come from the lfsr, model holds them in arrays
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module uwb_tb_top;
    import uwb_pkg::*;
    localparam logic [11:0] A1 = {UWB_IDX_W1_BASE, 2'b00};
    localparam logic [11:0] A2 = {UWB_IDX_W2_BASE, 2'b00};
    localparam logic [11:0] APG = {UWB_IDX_PGCTL, 2'b00};
    localparam logic [11:0] AXB = {UWB_IDX_W1_XBASE, 2'b00};
    localparam logic [11:0] ASU = {UWB_IDX_W1_SETUP, 2'b00};
    localparam logic [31:0] XB = 32'hABCD_E000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic sec_valid, sec_io, fwd_valid, fwd_win2;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, fwd_addr, sec_addr, rd, lf, a, m, lastx;
    logic [31:0] su[4] = '{32'hFFFF_F008, 32'h8000_0000, 32'hFFFF_FF01, 32'hFFFF_FFC1};
    logic [31:0] bw[4] = '{32'h1234_5FFF, 32'hFFFF_FFFF, 32'h0000_12FF, 32'h0000_12FF};
    logic [31:0] rb[4] = '{32'h1234_5008, 32'h8000_0000, 32'h0000_1201, 32'h0000_12C1};
    logic [31:0] ha[4] = '{32'h1234_5678, 32'h8765_4321, 32'h0000_12AB, 32'h0000_12FB};
    logic [31:0] ma[4] = '{32'h1234_6678, 32'h0765_4321, 32'h0000_13AB, 32'h0000_12BB};
    logic [31:0] pg_val[64];
    logic [63:0] pg_en;
    int n_fail, samples_checked;
    uwb_top uwb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sec_valid(sec_valid), .sec_addr(sec_addr),
        .sec_io(sec_io), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_win2(fwd_win2));
    uwb_sec_partner uwb_sec_partner_i (.pclk(pclk), .sec_valid(sec_valid),
        .sec_addr(sec_addr), .sec_io(sec_io));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            print_verdict();
        end
    endtask
    task automatic chk_rd(input logic [11:0] ad, input logic [31:0] e, input string nm);
        apb(1'b0, ad, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask
    task automatic claim(input logic [31:0] x, input logic io, input logic hit,
        input logic [31:0] xa, input logic w2, input string nm);
        uwb_sec_partner_i.issue(x, io, 1);
        @(posedge pclk);
        #1;
        `CHK(nm, hit, fwd_valid)
        if (hit) begin
            lastx = xa;
            `CHK(nm, xa, fwd_addr)
            `CHK(nm, w2, fwd_win2)
        end
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        n_fail = 0;
        samples_checked = 0;
        pg_en = 64'h0;
        lf = 32'h6374;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk_rd(A1, 32'h0, "w1 reset");
        chk_rd(A2, 32'h0, "w2 reset");
        apb(1'b1, A1, 32'hFFFF_FFFF);
        chk_rd(A1, 32'h0, "w1 ro when off");
        claim(32'h0000_0000, 1'b0, 1'b0, 32'h0, 1'b0, "w1 off");
        apb(1'b1, 12'h004, 32'h5);
        `CHK("unmapped err", 1'b1, err)
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK("unmapped rd err", 1'b1, err)
        `CHK("unmapped rd data", 32'h0000_0000, rd)
        $display("test reset done");
        apb(1'b1, AXB, XB);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ASU, su[i]);
            apb(1'b1, A1, bw[i]);
            m = {1'b1, su[i][30:6], 6'h00};
            chk_rd(A1, rb[i], "w1 base");
            claim(ha[i], su[i][0], 1'b1, (XB & m) | (ha[i] & ~m), 1'b0, "w1 hit");
            claim(ma[i], su[i][0], 1'b0, 32'h0, 1'b0, "w1 miss");
            claim(ha[i], !su[i][0], 1'b0, 32'h0, 1'b0, "w1 type");
        end
        apb(1'b1, ASU, 32'h0);
        $display("test window1 done");
        apb(1'b1, APG, 32'h11);
        apb(1'b1, A2, 32'hFFFF_FFFF);
        chk_rd(A2, 32'h8000_0000, "w2 2GB");
        apb(1'b1, APG, 32'h101);
        apb(1'b1, A2, 32'hFFFF_FFFF);
        chk_rd(A2, 32'hFFFF_8008, "w2 32KB");
        apb(1'b1, APG, 32'h100);
        apb(1'b1, A2, 32'hFFFF_FFFF);
        chk_rd(A2, 32'hFFFF_C008, "w2 16KB");
        apb(1'b1, A2, 32'h4000_0000);
        for (int p = 0; p < 64; p++) begin
            lf = lfsr(lf);
            pg_val[p] = lf;
            pg_en[p] = lf[0];
            apb(1'b1, 12'h400 + 12'(4 * p), lf);
        end
        for (int k = 0; k < 40; k++) begin
            lf = lfsr(lf);
            a = {18'h10000, lf[13:0]};
            claim(a, 1'b0, pg_en[a[13:8]], {pg_val[a[13:8]][31:8], a[7:0]}, 1'b1,
                "w2 page");
        end
        claim(32'h4000_4000, 1'b0, 1'b0, 32'h0, 1'b1, "w2 range");
        claim(32'h4000_0100, 1'b1, 1'b0, 32'h0, 1'b1, "w2 io");
        chk_rd({UWB_IDX_LAST_FWD, 2'b00}, lastx, "last fwd");
        chk_rd(12'h400, pg_val[0], "lut entry");
        $display("test window2 done");
        print_verdict();
    end
endmodule // uwb_tb_top

// ==== testbench/uwb_top_sva.sv ====
// Purpose: port checker for uwb_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes: one wait state per apb access, claims two edges after request
`timescale 1ns/10ps
module uwb_top_sva
    import uwb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sec_valid,
    input wire logic [31:0] sec_addr,
    input wire logic sec_io,
    input wire logic fwd_valid,
    input wire logic [31:0] fwd_addr,
    input wire logic fwd_win2
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_unmapped: assert property (psel && !penable && paddr[11:2] == 10'h001
        |=> ##1 pready && pslverr)
        else $error("unmapped access without error");
    a_err_rd_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("error read returned data");
    a_w2_ro_zero: assert property (pready && !pwrite && paddr[11:2] == UWB_IDX_W2_BASE
        |-> prdata[13:4] == 10'h000 && prdata[2:0] == 3'h0)
        else $error("window 2 fixed bits not zero");
    a_w1_ro_zero: assert property (pready && !pwrite && paddr[11:2] == UWB_IDX_W1_BASE
        |-> prdata[5:4] == 2'h0)
        else $error("window 1 reserved bits not zero");
    a_fwd_cause: assert property (fwd_valid |-> $past(sec_valid, 2))
        else $error("claim without request two cycles before");
    a_w2_mem_only: assert property (fwd_valid && fwd_win2 |-> !$past(sec_io, 2))
        else $error("window 2 claimed io");
    a_fwd_hold: assert property (!fwd_valid |-> $stable(fwd_addr))
        else $error("forward address moved without claim");
    c_w1_claim: cover property (fwd_valid && !fwd_win2);
    c_w2_claim: cover property (fwd_valid && fwd_win2);
    c_err: cover property (pslverr);
endmodule // uwb_top_sva
bind uwb_top uwb_top_sva uwb_top_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sec_valid(sec_valid),
    .sec_addr(sec_addr), .sec_io(sec_io), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .fwd_win2(fwd_win2));
